// ===== charge_timer_edge_control.sv
`timescale 1ns/1ps
`default_nettype none
module charge_timer_edge_control (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output var  logic [31:0]                     prdata,
	output var  logic                            pready,
	output var  logic                            pslverr,
	input  wire charge_timer_pkg::edge_sources_t edge_in,
	input  wire logic                            delay_comparator,
	output var  charge_timer_pkg::analog_ctrl_t  analog,
	output var  logic                            conversion_start,
	output var  logic                            delay_pulse,
	output var  logic                            irq
);
	logic [7:0] edge_control_high;
	logic [7:0] edge_control_low;
	logic [7:0] current_control;
	logic       unit_flag;
	logic       unit_irq_enable;
	logic [3:0] src_sync;
	logic       comp_sync;
	logic       chan_one_level;
	logic       chan_two_level;
	logic       hit_one;
	logic       hit_two;
	logic       source_was_on;
	logic       next_source_on;
	logic       both_prev;
	logic       wr_en;
	logic       low_write;
	logic       addr_ok;
	logic [7:0] wr_byte;

	// Synchronise every selectable source and the comparator
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			level_sync u_sync (
				.pclk     (pclk),
				.presetn  (presetn),
				.async_in (edge_in[g]),
				.sync_out (src_sync[g])
			);
		end
	endgenerate

	level_sync u_comp_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (delay_comparator),
		.sync_out (comp_sync)
	);

	// Source select, index matches struct bit order
	function automatic logic pick(input logic [3:0] s, input logic [1:0] code);
		pick = s[code];
	endfunction

	// Polarity matched level per channel
	assign chan_one_level = pick(src_sync, edge_control_low[charge_timer_pkg::BIT_ONE_SRC +: 2])
		~^ edge_control_low[charge_timer_pkg::BIT_ONE_POL];
	assign chan_two_level = pick(src_sync, edge_control_low[charge_timer_pkg::BIT_TWO_SRC +: 2])
		~^ edge_control_low[charge_timer_pkg::BIT_TWO_POL];

	// Detection gated by enable and unblock; channel two also by ordering
	assign hit_one = edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE]
		& edge_control_high[charge_timer_pkg::BIT_EDGE_UNBLOCK] & chan_one_level;
	assign hit_two = edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE]
		& edge_control_high[charge_timer_pkg::BIT_EDGE_UNBLOCK] & chan_two_level
		& (~edge_control_high[charge_timer_pkg::BIT_ORDER_ENABLE]
		| edge_control_low[charge_timer_pkg::BIT_ONE_SEEN]);

	// APB decode, zero wait states
	assign wr_en   = psel & penable & pwrite;
	assign low_write = wr_en & (paddr == charge_timer_pkg::ADDR_CTRL_LOW);
	assign wr_byte = pwdata[7:0];
	always_comb begin
		case (paddr)
			charge_timer_pkg::ADDR_CTRL_HIGH,
			charge_timer_pkg::ADDR_CTRL_LOW,
			charge_timer_pkg::ADDR_CURRENT,
			charge_timer_pkg::ADDR_FLAGS,
			charge_timer_pkg::ADDR_ENABLES: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Control high register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_control_high <= charge_timer_pkg::RESET_CTRL_HIGH;
		end else if (wr_en && paddr == charge_timer_pkg::ADDR_CTRL_HIGH) begin
			edge_control_high <= wr_byte & charge_timer_pkg::HIGH_WR_MASK;
		end
	end

	// Control low register; hardware set wins over a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_control_low <= charge_timer_pkg::RESET_CTRL_LOW;
		end else begin
			if (wr_en && paddr == charge_timer_pkg::ADDR_CTRL_LOW) begin
				edge_control_low <= wr_byte;
			end
			if (hit_one) begin
				edge_control_low[charge_timer_pkg::BIT_ONE_SEEN] <= 1'b1;
			end
			if (hit_two) begin
				edge_control_low[charge_timer_pkg::BIT_TWO_SEEN] <= 1'b1;
			end
		end
	end

	// Current range and trim register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_control <= charge_timer_pkg::RESET_CURRENT;
		end else if (wr_en && paddr == charge_timer_pkg::ADDR_CURRENT) begin
			current_control <= wr_byte;
		end
	end

	// Exactly one status bit drives the source
	assign next_source_on = edge_control_low[charge_timer_pkg::BIT_ONE_SEEN]
		^ edge_control_low[charge_timer_pkg::BIT_TWO_SEEN];

	// Analog steering outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog <= '0;
		end else begin
			analog.source_on  <= next_source_on & edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE]
				& (current_control[charge_timer_pkg::BIT_RANGE +: 2] != charge_timer_pkg::RANGE_OFF)
				& ~edge_control_high[charge_timer_pkg::BIT_DISCHARGE];
			analog.discharge  <= edge_control_high[charge_timer_pkg::BIT_DISCHARGE];
			analog.range      <= current_control[charge_timer_pkg::BIT_RANGE +: 2];
			analog.trim       <= current_control[charge_timer_pkg::BIT_TRIM +: 6];
			analog.delay_mode <= edge_control_high[charge_timer_pkg::BIT_DELAY_SELECT];
		end
	end

	// Interrupt flag on source off transition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_was_on   <= 1'b0;
			unit_flag       <= 1'b0;
			unit_irq_enable <= 1'b0;
			irq             <= 1'b0;
		end else begin
			source_was_on <= next_source_on;
			if (wr_en && paddr == charge_timer_pkg::ADDR_ENABLES) begin
				unit_irq_enable <= wr_byte[0];
			end
			if (source_was_on && !next_source_on) begin
				unit_flag <= 1'b1;
			end else if (wr_en && paddr == charge_timer_pkg::ADDR_FLAGS && !wr_byte[0]) begin
				unit_flag <= 1'b0;
			end
			irq <= unit_flag & unit_irq_enable;
		end
	end

	// Conversion trigger when both edges have been seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			both_prev        <= 1'b0;
			conversion_start <= 1'b0;
		end else begin
			both_prev <= &edge_control_low[1:0];
			conversion_start <= (&edge_control_low[1:0]) & ~both_prev
				& edge_control_high[charge_timer_pkg::BIT_TRIGGER]
				& edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE];
		end
	end

	// Delay pulse: source run, ended by comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_pulse <= 1'b0;
		end else begin
			delay_pulse <= edge_control_high[charge_timer_pkg::BIT_DELAY_SELECT]
				& edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE]
				& next_source_on & ~comp_sync;
		end
	end

	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					charge_timer_pkg::ADDR_CTRL_HIGH: prdata <= {24'h00_0000, edge_control_high};
					charge_timer_pkg::ADDR_CTRL_LOW:  prdata <= {24'h00_0000, edge_control_low};
					charge_timer_pkg::ADDR_CURRENT:   prdata <= {24'h00_0000, current_control};
					charge_timer_pkg::ADDR_FLAGS:     prdata <= {31'h0000_0000, unit_flag};
					charge_timer_pkg::ADDR_ENABLES:   prdata <= {31'h0000_0000, unit_irq_enable};
					default:                          prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks: source steering follows the status pair
	chk_source_exact_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		analog.source_on |-> $past(next_source_on))
		else $error("source on without one flag");
	chk_range_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		analog.source_on |-> (analog.range != charge_timer_pkg::RANGE_OFF))
		else $error("source on with range off");
	chk_discharge_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		edge_control_high[charge_timer_pkg::BIT_DISCHARGE] |=> !analog.source_on)
		else $error("source on in discharge");
	chk_enable_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		!edge_control_high[charge_timer_pkg::BIT_UNIT_ENABLE] |=> !analog.source_on)
		else $error("source on while disabled");

	// Checks: status bits set by level, held, blocked and ordered
	chk_level_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		hit_one |=> edge_control_low[charge_timer_pkg::BIT_ONE_SEEN])
		else $error("channel one level not seen");
	chk_level_two: assert property (
		@(posedge pclk) disable iff (!presetn)
		hit_two |=> edge_control_low[charge_timer_pkg::BIT_TWO_SEEN])
		else $error("channel two level not seen");
	chk_one_seen_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(edge_control_low[charge_timer_pkg::BIT_ONE_SEEN] && !low_write)
		|=> edge_control_low[charge_timer_pkg::BIT_ONE_SEEN])
		else $error("channel one status lost");
	chk_two_seen_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(edge_control_low[charge_timer_pkg::BIT_TWO_SEEN] && !low_write)
		|=> edge_control_low[charge_timer_pkg::BIT_TWO_SEEN])
		else $error("channel two status lost");
	chk_blocked_no_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!edge_control_high[charge_timer_pkg::BIT_EDGE_UNBLOCK] && !low_write
		&& !edge_control_low[charge_timer_pkg::BIT_ONE_SEEN])
		|=> !edge_control_low[charge_timer_pkg::BIT_ONE_SEEN])
		else $error("status set while edges blocked");
	chk_order_two: assert property (
		@(posedge pclk) disable iff (!presetn)
		(edge_control_high[charge_timer_pkg::BIT_ORDER_ENABLE] && !low_write
		&& !edge_control_low[charge_timer_pkg::BIT_ONE_SEEN]
		&& !edge_control_low[charge_timer_pkg::BIT_TWO_SEEN])
		|=> !edge_control_low[charge_timer_pkg::BIT_TWO_SEEN])
		else $error("channel two before channel one");

	// Checks: interrupt flag and request
	chk_flag_on_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		(source_was_on && !next_source_on) |=> unit_flag)
		else $error("flag missed on source off");
	chk_irq_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq |-> $past(unit_irq_enable))
		else $error("irq without enable");
	chk_irq_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq == ($past(unit_flag) && $past(unit_irq_enable)))
		else $error("irq does not follow flag");

	// Checks: conversion trigger and delay pulse
	chk_trigger_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		conversion_start |=> !conversion_start)
		else $error("trigger longer than one cycle");
	chk_trigger_both: assert property (
		@(posedge pclk) disable iff (!presetn)
		conversion_start |-> ($past(edge_control_low[charge_timer_pkg::BIT_ONE_SEEN])
		&& $past(edge_control_low[charge_timer_pkg::BIT_TWO_SEEN])))
		else $error("trigger before second edge");
	chk_pulse_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		delay_pulse |-> analog.delay_mode)
		else $error("delay pulse outside delay mode");

	// Main scenarios reached
	cov_measure: cover property (@(posedge pclk) disable iff (!presetn)
		analog.source_on ##[1:200] !analog.source_on);
	cov_ordered_wait: cover property (@(posedge pclk) disable iff (!presetn)
		edge_control_high[charge_timer_pkg::BIT_ORDER_ENABLE] && chan_two_level
		&& !edge_control_low[charge_timer_pkg::BIT_ONE_SEEN]);
	cov_trigger: cover property (@(posedge pclk) disable iff (!presetn) conversion_start);
	cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	cov_delay_pulse: cover property (@(posedge pclk) disable iff (!presetn) delay_pulse ##1 !delay_pulse);
endmodule
`default_nettype wire

// ===== charge_timer_edge_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charge_timer_edge_control_tb;
	localparam logic [11:0] A_HI = charge_timer_pkg::ADDR_CTRL_HIGH;
	localparam logic [11:0] A_LO = charge_timer_pkg::ADDR_CTRL_LOW;
	localparam logic [11:0] A_CU = charge_timer_pkg::ADDR_CURRENT;
	localparam logic [11:0] A_FL = charge_timer_pkg::ADDR_FLAGS;
	localparam logic [11:0] A_EN = charge_timer_pkg::ADDR_ENABLES;
	logic                            pclk;
	logic                            presetn;
	logic                            psel;
	logic                            penable;
	logic                            pwrite;
	logic [11:0]                     paddr;
	logic [31:0]                     pwdata;
	logic [31:0]                     prdata;
	logic                            pready;
	logic                            pslverr;
	logic [3:0]                      levels;
	logic                            cmp_level;
	logic                            conversion_start;
	logic                            delay_pulse;
	logic                            irq;
	logic                            err_seen;
	logic [31:0]                     rd;
	logic [7:0]                      cfg;
	int                              conversions;
	int                              n_mismatch;
	int                              compares;
	charge_timer_pkg::edge_sources_t edge_in;
	logic                            delay_comparator;
	charge_timer_pkg::analog_ctrl_t  analog;

	charge_timer_edge_control i_charge_timer_edge_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .edge_in(edge_in),
		.delay_comparator(delay_comparator), .analog(analog), .conversion_start(conversion_start),
		.delay_pulse(delay_pulse), .irq(irq)
	);
	charge_timer_far_side i_charge_timer_far_side (
		.pclk(pclk), .presetn(presetn), .levels(levels), .cmp_level(cmp_level),
		.conversion_start(conversion_start), .edge_in(edge_in), .delay_comparator(delay_comparator),
		.conversions(conversions)
	);

	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic end_sim();
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer: setup, access held until pready
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		@(posedge pclk);
		penable <= 1'b1;
		// Access phase held until the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd       = prdata;
		err_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read a register and compare
	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input string what);
		apb(1'b0, addr, '0);
		chk(what, rd, exp);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// Bring-up: range and trim, edges, discharge, disable, clear, unblock, enable
	task automatic start(input logic [7:0] cur, input logic [7:0] low, input logic [7:0] hi);
		apb(1'b1, A_CU, 32'(cur));
		apb(1'b1, A_LO, 32'(low & 8'hfc));
		apb(1'b1, A_HI, 32'(hi | 8'h02));
		apb(1'b1, A_HI, 32'(hi));
		apb(1'b1, A_LO, 32'(low & 8'hfc));
		apb(1'b1, A_HI, 32'(hi | 8'h08));
		apb(1'b1, A_HI, 32'(hi | 8'h88));
	endtask

	// Hang guard
	initial begin
		#2_000_000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		{levels, cmp_level, psel, penable, pwrite, paddr, pwdata} = '0;
		n_mismatch = 0;
		compares = 0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and a refused address
		rdchk(A_HI, 32'h0000_0000, "edge_control_high");
		rdchk(A_LO, 32'h0000_0000, "edge_control_low");
		rdchk(A_CU, 32'h0000_0000, "current_control");
		chk("analog", 32'(analog), 32'h0000_0000);
		rdchk(12'h014, 32'h0000_0000, "unmapped data");
		chk("unmapped error", 32'(err_seen), 32'h0000_0001);
		// Trim and range reach the analog side
		apb(1'b1, A_CU, 32'h0000_0086);
		rdchk(A_CU, 32'h0000_0086, "current_control");
		chk("mapped error", 32'(err_seen), 32'h0000_0000);
		chk("trim", 32'(analog.trim), 32'h0000_0021);
		chk("range", 32'(analog.range), 32'h0000_0002);
		// Every source code on both channels, high response, no ordering
		for (int ch = 0; ch < 2; ch++) begin
			for (int c = 0; c < 4; c++) begin
				levels <= '0;
				cfg = ch ? 8'(8'h90 | (c << 5) | ((3 - c) << 2)) : 8'(8'h90 | (c << 2) | ((3 - c) << 5));
				start(8'h01, cfg, 8'h00);
				levels <= 4'(1 << c);
				tick(6);
				rdchk(A_LO, 32'(cfg) | (ch ? 2 : 1), "status set");
				chk("source_on", analog.source_on, 1);
				levels <= '0;
				tick(6);
				rdchk(A_LO, 32'(cfg) | (ch ? 2 : 1), "status held");
			end
		end
		// Blocked or disabled unit ignores a matching level
		start(8'h01, 8'h9c, 8'h00);
		apb(1'b1, A_HI, 32'h0000_0080);
		levels <= 4'b1000;
		tick(6);
		rdchk(A_LO, 32'h0000_009c, "blocked status");
		apb(1'b1, A_HI, 32'h0000_0008);
		tick(6);
		rdchk(A_LO, 32'h0000_009c, "disabled status");
		// Polarity changed to match the present level sets the bit at once
		levels <= '0;
		apb(1'b1, A_HI, 32'h0000_0088);
		apb(1'b1, A_LO, 32'h0000_008c);
		tick(6);
		rdchk(A_LO, 32'h0000_008d, "polarity match");
		// Ordered measurement with conversion trigger and interrupt
		levels <= '0;
		start(8'h01, 8'hdc, 8'h05);
		apb(1'b1, A_FL, 32'h0000_0000);
		apb(1'b1, A_EN, 32'h0000_0001);
		rdchk(A_EN, 32'h0000_0001, "irq enable");
		tick(2);
		chk("irq idle", irq, 0);
		levels <= 4'b0100;
		tick(6);
		rdchk(A_LO, 32'h0000_00dc, "channel two first");
		levels <= 4'b1000;
		tick(6);
		chk("source_on", analog.source_on, 1);
		levels <= 4'b1100;
		tick(6);
		rdchk(A_LO, 32'h0000_00df, "both seen");
		chk("source_on", analog.source_on, 0);
		chk("conversions", conversions, 1);
		chk("irq", irq, 1);
		apb(1'b1, A_EN, 32'h0000_0000);
		tick(2);
		chk("irq masked", irq, 0);
		rdchk(A_FL, 32'h0000_0001, "flag");
		apb(1'b1, A_FL, 32'h0000_0000);
		rdchk(A_FL, 32'h0000_0000, "flag cleared");
		// Software steering, delay pulse, discharge and range off
		levels <= '0;
		tick(6);
		apb(1'b1, A_LO, 32'h0000_00dc);
		apb(1'b1, A_HI, 32'h0000_0098);
		apb(1'b1, A_LO, 32'h0000_00dd);
		tick(2);
		chk("source_on", analog.source_on, 1);
		chk("delay_pulse", delay_pulse, 1);
		chk("delay_mode", analog.delay_mode, 1);
		cmp_level <= 1'b1;
		tick(6);
		chk("pulse end", delay_pulse, 0);
		apb(1'b1, A_HI, 32'h0000_009a);
		tick(2);
		chk("discharge", analog.discharge, 1);
		chk("grounded", analog.source_on, 0);
		apb(1'b1, A_HI, 32'h0000_0098);
		apb(1'b1, A_LO, 32'h0000_00df);
		tick(2);
		chk("both set off", analog.source_on, 0);
		apb(1'b1, A_CU, 32'h0000_0084);
		apb(1'b1, A_LO, 32'h0000_00de);
		tick(2);
		chk("range off", analog.source_on, 0);
		end_sim();
	end
endmodule
`default_nettype wire

// ===== charge_timer_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module charge_timer_far_side (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic [3:0]                      levels,
	input  wire logic                            cmp_level,
	input  wire logic                            conversion_start,
	output var  charge_timer_pkg::edge_sources_t edge_in,
	output var  logic                            delay_comparator,
	output var  int                              conversions
);
	// Sources and comparator move off the clock grid, as real async pins do
	initial edge_in = '0;
	initial delay_comparator = 1'b0;
	always @(levels) edge_in <= #13 charge_timer_pkg::edge_sources_t'(levels);
	always @(cmp_level) delay_comparator <= #17 cmp_level;

	// Converter side counts every start request it receives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			conversions <= 0;
		else if (conversion_start)
			conversions <= conversions + 1;
	end
endmodule
`default_nettype wire

// ===== charge_timer_pkg.sv
// Behaviour
// - Channel two polarity bit 7: one responds to high level, zero to low.
// - Channel two source bits 6-5: 11 pin one, 10 pin two, 01/00 capture units.
// - Channel one polarity bit 4: one responds to high level, zero to low.
// - Channel one source bits 3-2 use the same four-way encoding.
// - Status bit 1 for channel two, bit 0 for channel one, set on response.
// - Inputs are levels; matching configuration sets the status bit at once.
// - Current source on only while exactly one status bit is set.
// - Software writes may set or clear status bits, steering the source.
// - Interrupt flag sets when source goes on to off; request needs enable.
// - With ordering on, channel two accepted only after channel one.
// - Six-bit trim field bits 7-2 is a signed value, zero nominal.
// - Range 11 hundred times, 10 ten times, 01 base, 00 source off.
// - Each trim step is about two percent, up to about 62 percent.
// - With trigger enabled, start a conversion once the second edge occurs.
// - Reset gives low polarity, no ordering, measurement mode, trigger off.
// - Delay select picks measurement or delay pulse mode ended by comparator.
// - Edge detection blocked while edge unblock is zero.
// - Unit runs only while unit enable is one.
// - Source output grounded while discharge bit is one.
// - Ordering enable requires channel one before channel two.
package charge_timer_pkg;
	localparam logic [11:0] ADDR_CTRL_HIGH = 12'h000;
	localparam logic [11:0] ADDR_CTRL_LOW  = 12'h004;
	localparam logic [11:0] ADDR_CURRENT   = 12'h008;
	localparam logic [11:0] ADDR_FLAGS     = 12'h00c;
	localparam logic [11:0] ADDR_ENABLES   = 12'h010;
	localparam logic [7:0]  RESET_CTRL_HIGH = 8'h00;
	localparam logic [7:0]  RESET_CTRL_LOW  = 8'h00;
	localparam logic [7:0]  RESET_CURRENT   = 8'h00;
	localparam logic [7:0]  HIGH_WR_MASK    = 8'h9f;
	localparam int BIT_UNIT_ENABLE  = 7;
	localparam int BIT_DELAY_SELECT = 4;
	localparam int BIT_EDGE_UNBLOCK = 3;
	localparam int BIT_ORDER_ENABLE = 2;
	localparam int BIT_DISCHARGE    = 1;
	localparam int BIT_TRIGGER      = 0;
	localparam int BIT_TWO_POL      = 7;
	localparam int BIT_TWO_SRC      = 5;
	localparam int BIT_ONE_POL      = 4;
	localparam int BIT_ONE_SRC      = 2;
	localparam int BIT_TWO_SEEN     = 1;
	localparam int BIT_ONE_SEEN     = 0;
	localparam int BIT_TRIM         = 2;
	localparam int BIT_RANGE        = 0;
	localparam logic [1:0] SRC_PIN_ONE = 2'b11;
	localparam logic [1:0] SRC_PIN_TWO = 2'b10;
	localparam logic [1:0] SRC_CAP_ONE = 2'b01;
	localparam logic [1:0] SRC_CAP_TWO = 2'b00;
	localparam logic [1:0] RANGE_OFF   = 2'b00;

	// Sources as they reach the unit
	typedef struct packed {
		logic pin_one;
		logic pin_two;
		logic cap_one;
		logic cap_two;
	} edge_sources_t;

	// Analog steering outputs
	typedef struct packed {
		logic       source_on;
		logic       discharge;
		logic [1:0] range;
		logic [5:0] trim;
		logic       delay_mode;
	} analog_ctrl_t;
endpackage

// ===== level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic stage_one;

	// Two flops into the pclk domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_one <= 1'b0;
			sync_out  <= 1'b0;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule
`default_nettype wire
